// *** src/gpc_defines.vh ***
// What this block does
// [R1] Each of pins 1-16 behaves per its own function-select field.
// [R2] Input pin with logic-level function shows its level in its status bit.
// [R3] Read-only status register holds pin n at bit n-1; zero after reset.
// [R4] Debounce enable at bit 13, default off; 32 kHz clock must run.
// [R5] Debounce time bits 19:16: 100 us, 1.5 ms, then 3 ms doubling to 768 ms.
// [R6] Every pin input raises separate rising-edge and falling-edge events.
// [R7] Edge event bits stay latched until cleared; readable and usable for interrupt.
// [R8] Pull-up enable bit 30, pull-down enable bit 29, both default enabled.
// [R9] Both pulls enabled gives a bus keeper holding the last pin level.
// [R10] Output level bit 15 is write-only and drives logic-level outputs.
// [R11] Invert bit flips the selected output, ignored for codes 0x000 and 0x002.
// [R12] Bit 14 selects CMOS or open drain; ignored for 0x000; 0x002 always CMOS.
// [R13] Drive strength bit 24: 0 is 4 mA, 1 is 8 mA, default 1.
// [R14] Direction bit 31: 0 output, 1 input, default input; ignored for 0x000, 0x002.
// [R15] Pin control words run from 0x0c08 for pin 1 to 0x0c44 for pin 16.
// [R16] Status bits show the debounced level and ignore the invert bit.
// [R17] With debounce on, a new level is taken only after staying stable long enough.
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

`define GPC_ADDR_W          16
`define GPC_OFS_STATUS      16'h0c00
`define GPC_OFS_CTRL_FIRST  16'h0c08
`define GPC_OFS_CTRL_LAST   16'h0c44

`define GPC_BIT_DIR         31
`define GPC_BIT_PU          30
`define GPC_BIT_PD          29
`define GPC_BIT_DRV         24
`define GPC_DBT_HI          19
`define GPC_DBT_LO          16
`define GPC_BIT_LVL         15
`define GPC_BIT_OD          14
`define GPC_BIT_DB          13
`define GPC_BIT_POL         12
`define GPC_FN_HI           9

`define GPC_RST_DIR         1'h1
`define GPC_RST_PU          1'h1
`define GPC_RST_PD          1'h1
`define GPC_RST_DRV         1'h1
`define GPC_RST_DBT         4'h0
`define GPC_RST_FN          10'h001

`define GPC_FN_ALT          10'h000
`define GPC_FN_LOGIC        10'h001
`define GPC_FN_DSP          10'h002

`define GPC_SLOW_HZ         32768
`define GPC_DB_US_0         100
`define GPC_DB_US_1         1500
`define GPC_DB_US_2         3000
`define GPC_DB_US_10        768000
// Microseconds to 32 kHz ticks, rounded up (32768/1e6 = 512/15625)
`define GPC_DB_TICKS(us)    (((us) * 512 + 15624) / 15625)

`endif

// *** src/gpc_pin_control.v ***
`timescale 1ns/1ps
`include "gpc_defines.vh"

module gpc_pin_control #(
   parameter NPIN          = 16,
   parameter DB_TICK_SHIFT = 0
) (
   // Clock and reset
   input  wire                    CLK_SYS,
   input  wire                    RESET,
   input  wire                    CLK_32K,
   // Register port
   input  wire [`GPC_ADDR_W-1:0]  REG_ADDR,
   input  wire                    REG_WR,
   input  wire [31:0]             REG_WDATA,
   input  wire                    REG_RD,
   output reg  [31:0]             REG_RDATA,
   // Pins
   input  wire [NPIN-1:0]         PIN_IN,
   output wire [NPIN-1:0]         PIN_OUT,
   output wire [NPIN-1:0]         PIN_OE,
   output wire [NPIN-1:0]         PIN_PULLUP_EN,
   output wire [NPIN-1:0]         PIN_PULLDOWN_EN,
   output wire [NPIN-1:0]         PIN_KEEPER_EN,
   output wire [NPIN-1:0]         PIN_KEEPER_LEVEL,
   output wire [NPIN-1:0]         PIN_DRIVE_8MA,
   // Function sources
   input  wire [NPIN-1:0]         ALT_OUT,
   input  wire [NPIN-1:0]         ALT_OE,
   input  wire [NPIN-1:0]         DSP_OUT,
   input  wire [NPIN-1:0]         DSP_OE,
   input  wire [NPIN-1:0]         FUNC_OUT,
   // Debounced levels and edge events
   output wire [NPIN-1:0]         PIN_LEVEL,
   output wire [NPIN-1:0]         RISE_EVENT,
   output wire [NPIN-1:0]         FALL_EVENT,
   input  wire [NPIN-1:0]         RISE_CLEAR,
   input  wire [NPIN-1:0]         FALL_CLEAR
);

   function [14:0] db_ticks;
      input [3:0] code;
      integer     us;
      integer     t;
      begin
         case (code)
            4'h0:    us = `GPC_DB_US_0;
            4'h1:    us = `GPC_DB_US_1;
            4'h2:    us = `GPC_DB_US_2;
            4'h3:    us = `GPC_DB_US_2 * 2;
            4'h4:    us = `GPC_DB_US_2 * 4;
            4'h5:    us = `GPC_DB_US_2 * 8;
            4'h6:    us = `GPC_DB_US_2 * 16;
            4'h7:    us = `GPC_DB_US_2 * 32;
            4'h8:    us = `GPC_DB_US_2 * 64;
            4'h9:    us = `GPC_DB_US_2 * 128;
            // Reserved codes fall back to the longest time
            default: us = `GPC_DB_US_10;
         endcase
         t = `GPC_DB_TICKS(us) >> DB_TICK_SHIFT;
         if (t < 1) begin
            t = 1;
         end
         db_ticks = t[14:0];
      end
   endfunction

   function ctrl_hit;
      input [`GPC_ADDR_W-1:0] a;
      begin
         ctrl_hit = (a >= `GPC_OFS_CTRL_FIRST) && (a <= `GPC_OFS_CTRL_LAST) && (a[1:0] == 2'h0);
      end
   endfunction

   wire [`GPC_ADDR_W-1:0] ctrl_ofs = REG_ADDR - `GPC_OFS_CTRL_FIRST;
   wire [3:0]             ctrl_idx = ctrl_ofs[5:2];
   wire                   ctrl_sel = ctrl_hit(REG_ADDR);

   // Slow clock sampled twice, third stage only for edge detect
   reg        slow_s1_ff;
   reg        slow_s2_ff;
   reg        slow_s3_ff;
   wire       slow_tick = slow_s2_ff & ~slow_s3_ff;

   // No reset here: a cleared chain would show a false slow edge on release
   always @(posedge CLK_SYS) begin
      slow_s1_ff <= CLK_32K;
      slow_s2_ff <= slow_s1_ff;
      slow_s3_ff <= slow_s2_ff;
   end

   // Blocks edge events on the first level load after reset
   reg        primed_ff;
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         primed_ff <= 1'h0;
      end else begin
         primed_ff <= 1'h1;
      end
   end

   wire [31:0] ctrl_rd [0:NPIN-1];

   genvar i;
   generate
      for (i = 0; i < NPIN; i = i + 1) begin : g_pin
         reg        dir_ff;
         reg        pu_ff;
         reg        pd_ff;
         reg        drv_ff;
         reg [3:0]  dbt_ff;
         reg        lvl_ff;
         reg        od_ff;
         reg        db_ff;
         reg        pol_ff;
         reg [9:0]  fn_ff;
         reg        in_s1_ff;
         reg        in_s2_ff;
         reg        stable_ff;
         reg [14:0] cnt_ff;
         reg        rise_ff;
         reg        fall_ff;
         reg        drive_val;
         reg        drive_en;
         reg        open_drain;
         wire       wr_me = REG_WR & ctrl_sel & (ctrl_idx == i);
         wire       differ = in_s2_ff ^ stable_ff;
         wire       db_done = slow_tick & (cnt_ff + 15'h1 >= db_ticks(dbt_ff));
         wire       take = primed_ff & differ & (~db_ff | db_done);
         wire       rise_now = take & in_s2_ff;
         wire       fall_now = take & ~in_s2_ff;

         always @(posedge CLK_SYS) begin
            if (RESET) begin
               dir_ff <= `GPC_RST_DIR;                                   // [R14]
               pu_ff  <= `GPC_RST_PU;                                    // [R8]
               pd_ff  <= `GPC_RST_PD;                                    // [R8]
               drv_ff <= `GPC_RST_DRV;                                   // [R13]
               dbt_ff <= `GPC_RST_DBT;
               lvl_ff <= 1'h0;
               od_ff  <= 1'h0;                                           // [R12]
               db_ff  <= 1'h0;                                           // [R4]
               pol_ff <= 1'h0;
               fn_ff  <= `GPC_RST_FN;
            end else if (wr_me) begin                                    // [R15]
               dir_ff <= REG_WDATA[`GPC_BIT_DIR];
               pu_ff  <= REG_WDATA[`GPC_BIT_PU];
               pd_ff  <= REG_WDATA[`GPC_BIT_PD];
               drv_ff <= REG_WDATA[`GPC_BIT_DRV];
               dbt_ff <= REG_WDATA[`GPC_DBT_HI:`GPC_DBT_LO];             // [R5]
               lvl_ff <= REG_WDATA[`GPC_BIT_LVL];                        // [R10]
               od_ff  <= REG_WDATA[`GPC_BIT_OD];
               db_ff  <= REG_WDATA[`GPC_BIT_DB];                         // [R4]
               pol_ff <= REG_WDATA[`GPC_BIT_POL];
               fn_ff  <= REG_WDATA[`GPC_FN_HI:0];                        // [R1]
            end
         end

         // Level bit reads as zero: it is write-only
         assign ctrl_rd[i] = {dir_ff, pu_ff, pd_ff, 4'h0, drv_ff, 4'h0, dbt_ff,
                              1'h0, od_ff, db_ff, pol_ff, 2'h0, fn_ff};  // [R10]

         // Pin sync runs through reset, so the first load sees the real level and no false edge follows
         always @(posedge CLK_SYS) begin
            in_s1_ff <= PIN_IN[i];
            in_s2_ff <= in_s1_ff;
         end

         always @(posedge CLK_SYS) begin
            if (RESET) begin
               stable_ff <= 1'h0;                                        // [R3]
               cnt_ff    <= 15'h0;
            end else begin
               if (!primed_ff) begin
                  stable_ff <= in_s2_ff;
                  cnt_ff    <= 15'h0;
               end else if (!differ) begin
                  cnt_ff <= 15'h0;                                       // [R17]
               end else if (take) begin
                  stable_ff <= in_s2_ff;                                 // [R16] [R17]
                  cnt_ff    <= 15'h0;
               end else if (slow_tick) begin
                  cnt_ff <= cnt_ff + 15'h1;                              // [R4] [R17]
               end
            end
         end

         // Set wins over a clear in the same cycle
         always @(posedge CLK_SYS) begin
            if (RESET) begin
               rise_ff <= 1'h0;
               fall_ff <= 1'h0;
            end else begin
               rise_ff <= rise_now | (rise_ff & ~RISE_CLEAR[i]);         // [R6] [R7]
               fall_ff <= fall_now | (fall_ff & ~FALL_CLEAR[i]);         // [R6] [R7]
            end
         end

         always @* begin
            open_drain = od_ff;
            case (fn_ff)
               `GPC_FN_ALT: begin
                  drive_val  = ALT_OUT[i];                               // [R11]
                  drive_en   = ALT_OE[i];                                // [R14]
                  open_drain = 1'h0;                                     // [R12]
               end
               `GPC_FN_DSP: begin
                  drive_val  = DSP_OUT[i];                               // [R11]
                  drive_en   = DSP_OE[i];                                // [R14]
                  open_drain = 1'h0;                                     // [R12]
               end
               `GPC_FN_LOGIC: begin
                  drive_val = lvl_ff ^ pol_ff;                           // [R10] [R11]
                  drive_en  = ~dir_ff;                                   // [R14]
               end
               default: begin
                  drive_val = FUNC_OUT[i] ^ pol_ff;                      // [R1] [R11]
                  drive_en  = ~dir_ff;                                   // [R14]
               end
            endcase
         end

         // Open drain only ever pulls low
         assign PIN_OUT[i]          = drive_val;
         assign PIN_OE[i]           = drive_en & (~open_drain | ~drive_val); // [R12]
         assign PIN_PULLUP_EN[i]    = pu_ff & ~pd_ff;                    // [R8]
         assign PIN_PULLDOWN_EN[i]  = pd_ff & ~pu_ff;                    // [R8]
         assign PIN_KEEPER_EN[i]    = pu_ff & pd_ff;                     // [R9]
         assign PIN_KEEPER_LEVEL[i] = in_s2_ff;                          // [R9]
         assign PIN_DRIVE_8MA[i]    = drv_ff;                            // [R13]
         assign PIN_LEVEL[i]        = stable_ff;                         // [R2] [R16]
         assign RISE_EVENT[i]       = rise_ff;
         assign FALL_EVENT[i]       = fall_ff;
      end
   endgenerate

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         REG_RDATA <= 32'h0;
      end else if (REG_RD) begin
         if (REG_ADDR == `GPC_OFS_STATUS) begin
            REG_RDATA <= {{(32-NPIN){1'b0}}, PIN_LEVEL};                 // [R2] [R3]
         end else if (ctrl_sel) begin
            REG_RDATA <= ctrl_rd[ctrl_idx];                              // [R15]
         end else begin
            REG_RDATA <= 32'h0;
         end
      end
   end

endmodule

// *** bench/gpc_pin_checker.sv ***
`timescale 1ns/1ps
module gpc_pin_checker #(
   parameter NPIN = 16
) (
   // Clock, reset and register port
   input wire            CLK_SYS,
   input wire            RESET,
   input wire [15:0]     REG_ADDR,
   input wire            REG_RD,
   input wire [31:0]     REG_RDATA,
   // Pins and events
   input wire [NPIN-1:0] PIN_IN,
   input wire [NPIN-1:0] PIN_OE,
   input wire [NPIN-1:0] PIN_PULLUP_EN,
   input wire [NPIN-1:0] PIN_PULLDOWN_EN,
   input wire [NPIN-1:0] PIN_KEEPER_EN,
   input wire [NPIN-1:0] PIN_DRIVE_8MA,
   input wire [NPIN-1:0] PIN_LEVEL,
   input wire [NPIN-1:0] RISE_EVENT,
   input wire [NPIN-1:0] FALL_EVENT,
   input wire [NPIN-1:0] RISE_CLEAR,
   input wire [NPIN-1:0] FALL_CLEAR
);
   reg  [2:0] rst_hist_ff;
   wire       settled;
   // The level loaded just after reset is not an edge, so edge checks wait
   assign settled = (rst_hist_ff == 3'h0);
   // Pin number of the control word on the address bus, wrapping at 16
   wire [3:0] rd_pin;
   assign rd_pin = REG_ADDR[5:2] - 4'h2;
   always @(posedge CLK_SYS) begin
      rst_hist_ff <= {rst_hist_ff[1:0], RESET};
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   a_rise_sets_event: assert property (settled |-> (PIN_LEVEL & ~$past(PIN_LEVEL) & ~RISE_EVENT) == 0)
      else $error("rise without event");
   a_fall_sets_event: assert property (settled |-> (~PIN_LEVEL & $past(PIN_LEVEL) & ~FALL_EVENT) == 0)
      else $error("fall without event");
   a_event_stays_latched: assert property (($past(RISE_EVENT) & ~$past(RISE_CLEAR) & ~RISE_EVENT) == 0
      && ($past(FALL_EVENT) & ~$past(FALL_CLEAR) & ~FALL_EVENT) == 0) else $error("event lost");
   a_reset_pin_defaults: assert property ($fell(RESET) |-> PIN_OE == 0 && &PIN_KEEPER_EN && &PIN_DRIVE_8MA)
      else $error("pin defaults wrong");
   a_keeper_excludes_pulls: assert property ((PIN_KEEPER_EN & (PIN_PULLUP_EN | PIN_PULLDOWN_EN)) == 0)
      else $error("keeper with pull");
   a_pull_bits_match: assert property (REG_RD && REG_ADDR >= 16'h0c08 && REG_ADDR <= 16'h0c44
      && REG_ADDR[1:0] == 2'h0 |=> REG_RDATA[24] == $past(PIN_DRIVE_8MA[rd_pin])
      && REG_RDATA[30] == $past(PIN_PULLUP_EN[rd_pin] | PIN_KEEPER_EN[rd_pin])
      && REG_RDATA[29] == $past(PIN_PULLDOWN_EN[rd_pin] | PIN_KEEPER_EN[rd_pin])) else $error("pull bits mismatch");
   a_unmapped_reads_zero: assert property (REG_RD && (REG_ADDR == 16'h0c04 || REG_ADDR > 16'h0c44
      || REG_ADDR[1:0] != 2'h0) |=> REG_RDATA == 32'h0) else $error("unmapped read not zero");
   a_level_bit_hidden: assert property (REG_RD && REG_ADDR >= 16'h0c08 && REG_ADDR <= 16'h0c44
      |=> REG_RDATA[15] == 1'b0 && REG_RDATA[28:25] == 4'h0) else $error("level bit readable");
   a_status_read_level: assert property (REG_RD && REG_ADDR == 16'h0c00
      |=> REG_RDATA == {16'h0, $past(PIN_LEVEL)}) else $error("status read wrong");
   a_level_follows_pin: assert property (settled |-> ((PIN_LEVEL ^ $past(PIN_LEVEL))
      & (PIN_LEVEL ^ $past(PIN_IN, 2)) & (PIN_LEVEL ^ $past(PIN_IN, 3))) == 0) else $error("level without pin");
   c_rise_event: cover property ($rose(RISE_EVENT[3]));
   c_status_read: cover property (REG_RD && REG_ADDR == 16'h0c00);
   c_event_clear: cover property ($fell(FALL_EVENT[0]));
endmodule

bind gpc_pin_control gpc_pin_checker #(.NPIN(NPIN)) gpc_pin_checker_i (.CLK_SYS(CLK_SYS), .RESET(RESET),
   .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PIN_IN(PIN_IN), .PIN_OE(PIN_OE),
   .PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_PULLDOWN_EN(PIN_PULLDOWN_EN), .PIN_KEEPER_EN(PIN_KEEPER_EN),
   .PIN_DRIVE_8MA(PIN_DRIVE_8MA), .PIN_LEVEL(PIN_LEVEL), .RISE_EVENT(RISE_EVENT), .FALL_EVENT(FALL_EVENT),
   .RISE_CLEAR(RISE_CLEAR), .FALL_CLEAR(FALL_CLEAR));

// *** bench/gpc_pad_model.sv ***
`timescale 1ns/1ps
module gpc_pad_model #(
   parameter NPIN = 16
) (
   // Block side
   input  wire [NPIN-1:0] pin_out,
   input  wire [NPIN-1:0] pin_oe,
   input  wire [NPIN-1:0] pullup_en,
   input  wire [NPIN-1:0] pulldown_en,
   input  wire [NPIN-1:0] keeper_en,
   input  wire [NPIN-1:0] keeper_level,
   // External circuit
   input  wire [NPIN-1:0] ext_en,
   input  wire [NPIN-1:0] ext_val,
   output wire [NPIN-1:0] pad
);
   // A floating pin reads the opposite of the kept level, so stale values never pass
   assign pad = (pin_oe & pin_out)
      | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & pullup_en)
      | (~pin_oe & ~ext_en & keeper_en & keeper_level)
      | (~pin_oe & ~ext_en & ~pullup_en & ~pulldown_en & ~keeper_en & ~keeper_level);
endmodule

// *** bench/gpc_pin_control_test.sv ***
`timescale 1ns/1ps
module gpc_pin_control_test;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         clk_32k = 1'b0;
   reg  [15:0] addr = 16'h0;
   reg         wr_en = 1'b0;
   reg  [31:0] wdata = 32'h0;
   reg         rd_en = 1'b0;
   reg  [15:0] alt_out = 16'h1, alt_oe = 16'h1, dsp_out = 16'h1, dsp_oe = 16'h1;
   reg  [15:0] rclr = 16'h0, fclr = 16'h0, ext_en = 16'hffff, ext_val = 16'h0;
   reg  [15:0] func_out = 16'h0;
   wire [31:0] rdata;
   wire [15:0] pin_in, pout, poe, pu, pd, ke, kl, drv, lvl, rise, fall;
   integer     n_errors = 0;
   integer     checked = 0;
   integer     i, t;

   initial begin
      forever #5 clk = ~clk;
   end
   // Slow clock sped up to 20 cycles a tick: debounce counts ticks, not time
   initial begin
      forever #100 clk_32k = ~clk_32k;
   end

   gpc_pin_control #(.NPIN(16), .DB_TICK_SHIFT(8)) gpc_pin_control_i (.CLK_SYS(clk), .RESET(rst),
      .CLK_32K(clk_32k), .REG_ADDR(addr), .REG_WR(wr_en), .REG_WDATA(wdata), .REG_RD(rd_en),
      .REG_RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe), .PIN_PULLUP_EN(pu),
      .PIN_PULLDOWN_EN(pd), .PIN_KEEPER_EN(ke), .PIN_KEEPER_LEVEL(kl), .PIN_DRIVE_8MA(drv),
      .ALT_OUT(alt_out), .ALT_OE(alt_oe), .DSP_OUT(dsp_out), .DSP_OE(dsp_oe), .FUNC_OUT(func_out),
      .PIN_LEVEL(lvl), .RISE_EVENT(rise), .FALL_EVENT(fall), .RISE_CLEAR(rclr), .FALL_CLEAR(fclr));
   gpc_pad_model #(.NPIN(16)) gpc_pad_model_i (.pin_out(pout), .pin_oe(poe), .pullup_en(pu),
      .pulldown_en(pd), .keeper_en(ke), .keeper_level(kl), .ext_en(ext_en), .ext_val(ext_val), .pad(pin_in));

   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task ticks(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task wr(input [15:0] a, input [31:0] d);
      begin
         @(negedge clk);
         addr = a;
         wdata = d;
         wr_en = 1'b1;
         @(negedge clk);
         wr_en = 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [31:0] exp, input string what);
      begin
         @(negedge clk);
         addr = a;
         rd_en = 1'b1;
         @(negedge clk);
         rd_en = 1'b0;
         chk(what, exp, rdata);
      end
   endtask
   task end_of_test;
      begin
         $display("Comparisons %0d, mismatches %0d", checked, n_errors);
         if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors = n_errors + 1;
      end_of_test;
   end

   initial begin
      ticks(20);
      rst = 1'b0;
      ticks(4);
      rd(16'h0c00, 32'h0, "status after reset");
      rd(16'h0c08, 32'he100_0001, "control defaults");
      chk("drive and enable", 32'hffff_0000, {drv, poe});
      chk("keeper default", 32'hffff, ke);
      ext_en = 16'h0;
      for (i = 0; i < 16; i = i + 1) begin
         t = 16'h0c08 + 4 * i;
         wr(t[15:0], 32'h0100_8001);
         chk("output high", 32'h3, {pout[i], poe[i]});
         rd(t[15:0], 32'h0100_0001, "level reads zero");
         ticks(5);
         rd(16'h0c00, 32'h1 << i, "status bit");
         wr(t[15:0], 32'h0100_9001);
         chk("inverted output", 32'h1, {pout[i], poe[i]});
         ticks(5);
      end
      chk("events latched", 32'hffff_ffff, {rise, fall});
      rclr = 16'hffff;
      fclr = 16'hffff;
      ticks(1);
      rclr = 16'h0;
      fclr = 16'h0;
      chk("events cleared", 32'h0, {rise, fall});
      wr(16'h0c08, 32'h8000_5000);
      chk("alternate drive", 32'h3, {pout[0], poe[0]});
      wr(16'h0c08, 32'h8000_5002);
      chk("dsp drive", 32'h3, {pout[0], poe[0]});
      wr(16'h0c0c, 32'h4000_c001);
      chk("open drain release", 32'h0, poe[1]);
      ticks(5);
      rd(16'h0c00, 32'h3, "pulled up pin");
      wr(16'h0c0c, 32'h4000_4001);
      chk("open drain low", 32'h1, {pout[1], poe[1]});
      wr(16'h0c10, 32'hc000_0001);
      chk("pull-up only", 32'h4, {pu[2], pd[2], ke[2]});
      wr(16'h0c10, 32'ha000_0001);
      chk("pull-down only", 32'h2, {pu[2], pd[2], ke[2]});
      wr(16'h0c10, 32'he000_0001);
      ext_val[2] = 1'b1;
      ext_en[2] = 1'b1;
      ticks(6);
      ext_en[2] = 1'b0;
      ticks(10);
      rd(16'h0c00, 32'h5, "keeper holds");
      wr(16'h0c14, 32'he10a_2001);
      ext_en[3] = 1'b1;
      ext_val[3] = 1'b1;
      ticks(1000);
      ext_val[3] = 1'b0;
      ticks(500);
      chk("glitch dropped", 32'h0, {rise[3], lvl[3]});
      ext_val[3] = 1'b1;
      for (t = 0; t < 3000 && lvl[3] !== 1'b1; t = t + 1) ticks(1);
      chk("longest debounce", 32'h1, t > 1800 && t < 2100);
      wr(16'h0c14, 32'he100_2001);
      ext_val[3] = 1'b0;
      for (t = 0; t < 3000 && lvl[3] !== 1'b0; t = t + 1) ticks(1);
      chk("shortest debounce", 32'h1, t < 60);
      func_out = 16'h0010;
      wr(16'h0c18, 32'h0000_1003);
      chk("other function inverted", 32'h1, {pout[4], poe[4]});
      func_out = 16'h0;
      ticks(1);
      chk("other function low in", 32'h3, {pout[4], poe[4]});
      rd(16'h0c04, 32'h0, "gap read");
      rd(16'h0c09, 32'h0, "unaligned read");
      wr(16'h0c48, 32'h0);
      rd(16'h0c44, 32'h0100_1001, "last pin word");
      rst = 1'b1;
      ticks(4);
      rst = 1'b0;
      ticks(4);
      rd(16'h0c14, 32'he100_0001, "defaults again");
      end_of_test;
   end
endmodule
